// file: rtl/scm_serial_config.sv
// serial configuration port, channel settings and device mode decode
// Overview of operation
// - mode field picks loops, oscillator source, zero delay; distribution always on
// - zero-delay dual loop: first loop feedback comes from a clock output
// - dual loop: first loop reference is input a or b
// - reference lost with holdover enabled freezes first loop tuning voltage
// - external oscillator with zero delay dual forces internal feedback
// - single loop: first loop off; zero delay feeds second loop from output
// - distribution: input b drives channels; oscillator may reach buffer and outputs
// - dual loop may double oscillator reference; oscillator buffered to outputs
// - 32-bit word: address in bits 4..0, data in bits 31..5
// - bit 31 first; data sampled on serial clock rising edge
// - latch line low while shifting; rising latch stores word
// - writing calibration register starts frequency calibration
// - auto sync: latch falling edge after write to registers 0..5 syncs
// - large divide or delay applies after three more serial clock rises
// - register 0 with reset bit restores defaults, other bits ignored
// - target address is the last five bits before latch rises
`timescale 1ns/1ns
`default_nettype none
module scm_serial_config (
    // clock and reset
    input wire logic ref_clk,
    input wire logic srst,
    // serial configuration pins
    input wire logic serial_clock_line,
    input wire logic serial_data_line,
    input wire logic serial_latch_line,
    // reference status
    input wire logic reference_lost,
    // avalon-mm slave
    input wire logic [scm_pkg::AV_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // mode and routing
    output var scm_pkg::scm_mode_t mode_state,
    output logic first_loop_ref_select,
    output logic first_loop_fb_from_output,
    output logic second_loop_fb_from_output,
    output logic loop_return_external,
    output logic second_loop_ref_doubled,
    output logic dist_from_reference_input_b,
    output logic osc_to_buffered_output,
    output logic [1:0] osc_to_clock_outputs,
    output logic tune_voltage_hold,
    // channel settings and events
    output var scm_pkg::scm_chan_t [scm_pkg::NUM_CH-1:0] channel_settings,
    output logic align_pulse,
    output logic cal_start
);
    import scm_pkg::*;

    function automatic scm_mode_t decode_mode(input logic [4:0] m);
        scm_mode_t r;
        r = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        case (m)
            MODE_DUAL: r = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
            MODE_DUAL_ZD: r = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
            MODE_DUAL_EXT: r = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
            MODE_DUAL_ZD_EXT: r = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
            MODE_SINGLE: r = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
            MODE_SINGLE_ZD: r = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
            MODE_SINGLE_EXT: r = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
            MODE_DIST: r = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
            default: r = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
        endcase
        return r;
    endfunction

    // serial front end
    logic sclk_q;
    logic le_q;
    logic [WORD_W-1:0] shift_q;
    logic [WORD_W-1:0] cfg_q [NUM_REGS];
    logic sclk_rise;
    logic le_rise;
    logic le_fall;
    logic [4:0] latch_addr;
    logic cfg_reset;
    logic cfg_write;

    assign sclk_rise = serial_clock_line & ~sclk_q;
    assign le_rise = serial_latch_line & ~le_q;
    assign le_fall = ~serial_latch_line & le_q;
    assign latch_addr = shift_q[4:0];
    assign cfg_reset = le_rise && latch_addr == 5'h00 && shift_q[RESET_BIT];
    assign cfg_write = le_rise && !cfg_reset;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sclk_q <= 1'b0;
            le_q <= 1'b0;
            shift_q <= '0;
        end else begin
            sclk_q <= serial_clock_line;
            le_q <= serial_latch_line;
            // no bit counter: the newest 32 bits always win
            if (sclk_rise) begin
                shift_q <= {shift_q[WORD_W-2:0], serial_data_line};
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst || cfg_reset) begin
            for (int r = 0; r < NUM_REGS; r++) begin
                cfg_q[r] <= CFG_RESET;
            end
        end else if (cfg_write) begin
            cfg_q[latch_addr] <= shift_q;
        end
    end

    // channel divide and delay with late apply
    scm_chan_t chan_q [NUM_CH];
    scm_chan_t stage_q [NUM_CH];
    logic [1:0] cnt_q [NUM_CH];
    logic [NUM_CH-1:0] pend_q;
    scm_chan_t chan_new;
    logic chan_fast;

    assign chan_new.div = shift_q[DIV_LSB +: DIV_W];
    assign chan_new.dly = shift_q[DLY_LSB +: DLY_W];
    assign chan_fast = chan_new.div <= DIV_FAST_MAX && chan_new.dly <= DLY_FAST_MAX;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        logic ch_wr;
        logic ch_done;
        assign ch_wr = cfg_write && latch_addr == 5'(i);
        assign ch_done = pend_q[i] && sclk_rise && cnt_q[i] == LATE_EDGES - 2'h1;
        always_ff @(posedge ref_clk) begin
            if (srst || cfg_reset) begin
                chan_q[i] <= '{DIV_RESET, DLY_RESET};
                stage_q[i] <= '{DIV_RESET, DLY_RESET};
                cnt_q[i] <= 2'h0;
                pend_q[i] <= 1'b0;
            end else if (ch_wr && chan_fast) begin
                chan_q[i] <= chan_new;
                pend_q[i] <= 1'b0;
            end else if (ch_wr) begin
                // large values wait for three more serial clock rises
                stage_q[i] <= chan_new;
                cnt_q[i] <= 2'h0;
                pend_q[i] <= 1'b1;
            end else if (ch_done) begin
                chan_q[i] <= stage_q[i];
                pend_q[i] <= 1'b0;
            end else if (pend_q[i] && sclk_rise) begin
                cnt_q[i] <= cnt_q[i] + 2'h1;
            end
        end
        assign channel_settings[i] = chan_q[i];
    end

    // mode decode and routing
    scm_ctrl_t ctrl_q;
    scm_mode_t mode_d;
    scm_mode_t mode_q;
    logic auto_sync_en;
    logic arm_q;
    logic tune_q;
    logic fb1_q;
    logic fb2_q;
    logic ext_ret_q;
    logic dbl_q;
    logic dist_b_q;
    logic ref_b_q;
    logic oscbuf_q;
    logic [1:0] oscclk_q;
    logic align_q;
    logic cal_q;

    assign mode_d = decode_mode(cfg_q[MODE_SYNC_REG][MODE_LSB +: 5]);
    assign auto_sync_en = cfg_q[MODE_SYNC_REG][AUTO_SYNC_BIT];

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            mode_q <= MODE_DEC_RESET;
            tune_q <= 1'b0;
            fb1_q <= 1'b0;
            fb2_q <= 1'b0;
            ext_ret_q <= 1'b0;
            dbl_q <= 1'b0;
            dist_b_q <= 1'b0;
            ref_b_q <= 1'b0;
            oscbuf_q <= 1'b0;
            oscclk_q <= 2'h0;
        end else begin
            mode_q <= mode_d;
            // tuning frozen only while the first loop actually runs
            tune_q <= ctrl_q.holdover && reference_lost && mode_q.first_loop_on;
            fb1_q <= mode_q.first_loop_on && mode_q.zero_delay;
            fb2_q <= !mode_q.first_loop_on && mode_q.second_loop_on && mode_q.zero_delay;
            // shared pin carries the external oscillator, so no external return then
            ext_ret_q <= mode_q.zero_delay && ctrl_q.ext_return && !mode_q.ext_osc;
            dbl_q <= mode_q.first_loop_on && ctrl_q.doubler;
            dist_b_q <= !mode_q.second_loop_on && !mode_q.mode_bad;
            ref_b_q <= mode_q.first_loop_on && ctrl_q.ref_b;
            oscbuf_q <= ctrl_q.osc_buffer && !mode_q.mode_bad;
            oscclk_q <= mode_q.mode_bad ? 2'h0 : ctrl_q.osc_clk_outs;
        end
    end

    // sync and calibration events
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            arm_q <= 1'b0;
            align_q <= 1'b0;
            cal_q <= 1'b0;
        end else begin
            align_q <= arm_q && le_fall;
            cal_q <= cfg_write && latch_addr == CAL_TRIG_REG;
            if (cfg_reset || le_fall) begin
                arm_q <= 1'b0;
            end else if (cfg_write && latch_addr < 5'(NUM_CH)) begin
                arm_q <= auto_sync_en;
            end
        end
    end

    // avalon-mm slave, one wait state on every access
    logic wait_q;
    logic [31:0] rdata_q;
    logic av_req;
    logic av_take;
    logic is_cfg;
    scm_status_t status;
    logic [31:0] rd_word;

    assign av_req = avs_read | avs_write;
    assign av_take = av_req && !wait_q;
    assign is_cfg = avs_address < CTRL_ADDR && avs_address[1:0] == 2'h0;
    assign status = '{18'h0, pend_q, arm_q, tune_q, mode_q};
    assign rd_word = is_cfg ? cfg_q[avs_address[6:2]] :
                     avs_address == CTRL_ADDR ? {24'h000000, ctrl_q} :
                     avs_address == STATUS_ADDR ? status : 32'h0000_0000;

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            wait_q <= 1'b1;
            rdata_q <= 32'h0000_0000;
            ctrl_q <= CTRL_RESET;
        end else begin
            wait_q <= !(av_req && wait_q);
            if (av_req && wait_q) begin
                rdata_q <= avs_read ? rd_word : 32'h0000_0000;
            end
            if (av_take && avs_write && avs_address == CTRL_ADDR && avs_byteenable[0]) begin
                ctrl_q <= {1'b0, avs_writedata[6:0]};
            end
        end
    end

    assign avs_readdata = rdata_q;
    assign avs_waitrequest = wait_q;
    assign mode_state = mode_q;
    assign first_loop_ref_select = ref_b_q;
    assign first_loop_fb_from_output = fb1_q;
    assign second_loop_fb_from_output = fb2_q;
    assign loop_return_external = ext_ret_q;
    assign second_loop_ref_doubled = dbl_q;
    assign dist_from_reference_input_b = dist_b_q;
    assign osc_to_buffered_output = oscbuf_q;
    assign osc_to_clock_outputs = oscclk_q;
    assign tune_voltage_hold = tune_q;
    assign align_pulse = align_q;
    assign cal_start = cal_q;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);

    a_shift_in_order: assert property (sclk_rise |=>
        shift_q == {$past(shift_q[WORD_W-2:0]), $past(serial_data_line)})
        else $error("serial bit not shifted in");
    a_latch_stores_word: assert property (cfg_write |=>
        cfg_q[$past(latch_addr)] == $past(shift_q))
        else $error("latched word not stored at its address");
    a_reset_word_clears: assert property (cfg_reset |=>
        cfg_q[0] == CFG_RESET && cfg_q[MODE_SYNC_REG] == CFG_RESET && pend_q == '0)
        else $error("reset word did not restore defaults");
    a_cal_one_pulse: assert property (
        cfg_write && latch_addr == CAL_TRIG_REG |=> cal_start ##1 !cal_start)
        else $error("calibration start not a single pulse");
    a_mode_single_zd: assert property (
        cfg_q[MODE_SYNC_REG][MODE_LSB +: 5] == MODE_SINGLE_ZD |=>
        mode_state.zero_delay && !mode_state.first_loop_on && mode_state.second_loop_on)
        else $error("single zero-delay mode decoded wrongly");
    a_dist_always_on: assert property (mode_state.dist_on)
        else $error("distribution not enabled");
    a_no_ext_return: assert property (mode_q.ext_osc |=> !loop_return_external)
        else $error("external return used with external oscillator");
    a_tune_hold_cause: assert property (
        ctrl_q.holdover && reference_lost && mode_q.first_loop_on |=> tune_voltage_hold)
        else $error("tuning voltage not held on reference loss");
    a_auto_sync_fall: assert property (arm_q && le_fall |=> align_pulse)
        else $error("no align pulse after latch fall");
    a_late_apply: assert property (
        g_ch[0].ch_wr && !chan_fast |=> pend_q[0] && $stable(chan_q[0]))
        else $error("large channel value applied early");
    a_late_done: assert property (g_ch[0].ch_done && !cfg_reset && !g_ch[0].ch_wr |=>
        chan_q[0] == $past(stage_q[0]) && !pend_q[0])
        else $error("staged channel value not applied");
    a_bus_one_wait: assert property (av_req && wait_q |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("bus answer not after one wait state");

    c_dist_mode: cover property (mode_q.dist_on && !mode_q.second_loop_on);
    c_align: cover property (align_pulse);
    c_cal: cover property (cal_start);
    c_late_apply: cover property (g_ch[0].ch_done);
endmodule // scm_serial_config
`default_nettype wire

// file: rtl/scm_pkg.sv
// constants and types of the serial configuration and mode decode block
package scm_pkg;
    // serial word layout
    localparam int WORD_W = 32;
    localparam int NUM_REGS = 32;
    localparam int NUM_CH = 6;
    localparam int RESET_BIT = 17;
    localparam int AUTO_SYNC_BIT = 8;
    localparam int MODE_LSB = 27;
    localparam int DIV_LSB = 5;
    localparam int DIV_W = 11;
    localparam int DLY_LSB = 16;
    localparam int DLY_W = 10;
    localparam logic [4:0] MODE_SYNC_REG = 5'h0B;
    localparam logic [4:0] CAL_TRIG_REG = 5'h1E;
    localparam logic [WORD_W-1:0] CFG_RESET = 32'h0000_0000;
    // late-apply thresholds and reset values for channel settings
    localparam logic [DIV_W-1:0] DIV_FAST_MAX = 11'h019;
    localparam logic [DLY_W-1:0] DLY_FAST_MAX = 10'h00C;
    localparam logic [1:0] LATE_EDGES = 2'h3;
    localparam logic [DIV_W-1:0] DIV_RESET = 11'h001;
    localparam logic [DLY_W-1:0] DLY_RESET = 10'h000;
    // device mode codes
    localparam logic [4:0] MODE_DUAL = 5'h00;
    localparam logic [4:0] MODE_DUAL_ZD = 5'h02;
    localparam logic [4:0] MODE_DUAL_EXT = 5'h03;
    localparam logic [4:0] MODE_DUAL_ZD_EXT = 5'h05;
    localparam logic [4:0] MODE_SINGLE = 5'h06;
    localparam logic [4:0] MODE_SINGLE_ZD = 5'h08;
    localparam logic [4:0] MODE_SINGLE_EXT = 5'h0B;
    localparam logic [4:0] MODE_DIST = 5'h10;
    // avalon register map, byte addresses
    localparam int AV_ADDR_W = 8;
    localparam logic [7:0] CTRL_ADDR = 8'h80;
    localparam logic [7:0] STATUS_ADDR = 8'h84;

    typedef struct packed {
        logic first_loop_on;
        logic second_loop_on;
        logic ext_osc;
        logic zero_delay;
        logic dist_on;
        logic mode_bad;
    } scm_mode_t;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [DLY_W-1:0] dly;
    } scm_chan_t;

    typedef struct packed {
        logic pad;
        logic [1:0] osc_clk_outs;
        logic osc_buffer;
        logic doubler;
        logic ext_return;
        logic ref_b;
        logic holdover;
    } scm_ctrl_t;

    typedef struct packed {
        logic [17:0] zero;
        logic [NUM_CH-1:0] pend;
        logic sync_armed;
        logic tune_hold;
        scm_mode_t mode;
    } scm_status_t;

    localparam scm_mode_t MODE_DEC_RESET = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
    localparam scm_ctrl_t CTRL_RESET = '0;
endpackage

// file: bench/scm_host_model.sv
// host-side driver of the three serial configuration lines
`timescale 1ns/1ns
`default_nettype none
module scm_host_model (
    // clock
    input wire logic ref_clk,
    // serial pins
    output logic sclk,
    output logic sdata,
    output logic slatch
);
    initial begin
        sclk = 1'b0;
        sdata = 1'b0;
        slatch = 1'b0;
    end

    // every level held at least two ref_clk cycles so the port sees it
    task automatic pulse(input logic b);
        @(posedge ref_clk) sdata <= b;
        @(posedge ref_clk) sclk <= 1'b1;
        repeat (2) @(posedge ref_clk);
        sclk <= 1'b0;
        @(posedge ref_clk);
    endtask

    // data toggles on every pulse, starting from the inverse of the last bit
    task automatic clocks(input int n);
        for (int i = 0; i < n; i++) pulse(~sdata);
    endtask

    task automatic send(input logic [31:0] w, input logic [7:0] pre, input int npre,
                        input int extra);
        for (int i = npre - 1; i >= 0; i--) pulse(pre[i]);
        for (int i = 31; i >= 0; i--) pulse(w[i]);
        @(posedge ref_clk) slatch <= 1'b1;
        repeat (2) @(posedge ref_clk);
        clocks(extra);
        @(posedge ref_clk) slatch <= 1'b0;
        sdata <= 1'b0;
        repeat (2) @(posedge ref_clk);
    endtask
endmodule // scm_host_model
`default_nettype wire

// file: bench/scm_serial_config_bench.sv
// self-checking bench of the serial configuration and mode decode block
`timescale 1ns/1ns
`default_nettype none
module scm_serial_config_bench;
    import scm_pkg::*;
    localparam logic [4:0] CODES [9] = '{5'h00, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0B,
                                         5'h10, 5'h1F};
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic sclk, sdata, slatch;
    logic reference_lost = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    scm_mode_t mode_state;
    logic fl_ref, fl_fb, sl_fb, ret_ext, dbl, dist_b, osc_buf, hold, align_pulse, cal_start;
    logic [1:0] osc_clk;
    scm_chan_t [NUM_CH-1:0] chans;
    int num_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int n_align = 0;
    int n_cal = 0;
    logic [31:0] seed = 32'h0000_002F;

    always #4 ref_clk = ~ref_clk;

    scm_host_model host (.ref_clk(ref_clk), .sclk(sclk), .sdata(sdata), .slatch(slatch));

    scm_serial_config uut (
        .ref_clk(ref_clk), .srst(srst), .serial_clock_line(sclk),
        .serial_data_line(sdata), .serial_latch_line(slatch), .reference_lost(reference_lost),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'h1), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .mode_state(mode_state),
        .first_loop_ref_select(fl_ref), .first_loop_fb_from_output(fl_fb),
        .second_loop_fb_from_output(sl_fb), .loop_return_external(ret_ext),
        .second_loop_ref_doubled(dbl), .dist_from_reference_input_b(dist_b),
        .osc_to_buffered_output(osc_buf), .osc_to_clock_outputs(osc_clk),
        .tune_voltage_hold(hold),
        .channel_settings(chans), .align_pulse(align_pulse), .cal_start(cal_start)
    );

    // pulses are one cycle wide, so they are counted rather than polled
    always @(posedge ref_clk) begin
        cycles++;
        if (cal_start === 1'b1) n_cal++;
        if (align_pulse === 1'b1) n_align++;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end

    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic scm_mode_t exp_mode(input logic [4:0] m);
        case (m)
            MODE_DUAL: return scm_mode_t'(6'h32);
            MODE_DUAL_ZD: return scm_mode_t'(6'h36);
            MODE_DUAL_EXT: return scm_mode_t'(6'h3A);
            MODE_DUAL_ZD_EXT: return scm_mode_t'(6'h3E);
            MODE_SINGLE: return scm_mode_t'(6'h12);
            MODE_SINGLE_ZD: return scm_mode_t'(6'h16);
            MODE_SINGLE_EXT: return scm_mode_t'(6'h1A);
            MODE_DIST: return scm_mode_t'(6'h02);
            default: return scm_mode_t'(6'h03);
        endcase
    endfunction

    task automatic check(input logic ok, input string what);
        comparisons++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("ERROR t=%0t %s", $time, what);
        end
    endtask

    task automatic av_req(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                          output logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= wd;
        if (wr) avs_write <= 1'b1;
        else avs_read <= 1'b1;
        // no local limit: only the bench timeout ends a stuck wait
        do begin
            @(posedge ref_clk);
            n++;
        end while (avs_waitrequest !== 1'b0);
        check(n == 2, "bus wait states");
        d = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // up to seven random junk bits ahead of each word must be shifted out
    task automatic put(input logic [31:0] w, input int extra);
        logic [31:0] r;
        r = rnd();
        host.send(w, r[7:0], int'(r[10:8]), extra);
        repeat (4) @(posedge ref_clk);
    endtask

    task automatic wrap_up();
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        logic [31:0] d;
        logic [31:0] w;
        logic [10:0] dv;
        logic [9:0] dl;
        scm_mode_t e;
        scm_chan_t exp_ch [NUM_CH];
        int n0;
        repeat (2) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        av_req(1'b0, STATUS_ADDR, 32'h0000_0000, d);
        check(d[5:0] === MODE_DEC_RESET, "reset mode");
        for (int i = 0; i < NUM_CH; i++) check(chans[i] === {DIV_RESET, DLY_RESET}, "reset ch");
        av_req(1'b0, 8'hC0, 32'h0000_0000, d);
        check(d === 32'h0000_0000, "unmapped read");
        // holdover, input b, external return, doubler, buffer; bit 7 is not stored
        av_req(1'b1, CTRL_ADDR, 32'h0000_00FF, d);
        av_req(1'b0, CTRL_ADDR, 32'h0000_0000, d);
        check(d === 32'h0000_007F, "ctrl readback");
        $display("test reset done");
        foreach (CODES[k]) begin
            d = rnd();
            reference_lost <= d[0];
            e = exp_mode(CODES[k]);
            put({CODES[k], 22'h0, MODE_SYNC_REG}, 0);
            check(mode_state === e, "mode decode");
            check(hold === (reference_lost & e.first_loop_on), "tune hold");
            check(dist_b === (CODES[k] == MODE_DIST), "dist source");
            check(osc_clk === (e.mode_bad ? 2'h0 : 2'h3), "osc outputs");
            if (e.first_loop_on) begin
                check(fl_ref === 1'b1, "ref select");
                check(dbl === 1'b1 && osc_buf === 1'b1, "osc path");
            end
            if (e.zero_delay) begin
                check(fl_fb === e.first_loop_on, "loop one return");
                check(sl_fb === !e.first_loop_on, "loop two return");
                check(ret_ext === !e.ext_osc, "external return");
            end
        end
        $display("test modes done");
        for (int i = 0; i < NUM_CH; i++) begin
            d = rnd();
            dv = (i == 0) ? DIV_FAST_MAX : 11'(d[7:0] % 26);
            dl = (i == 0) ? DLY_FAST_MAX : 10'(d[15:8] % 13);
            w = {6'h00, dl, dv, 5'(i)};
            exp_ch[i] = '{dv, dl};
            put(w, 0);
            check(chans[i] === exp_ch[i], "channel load");
            av_req(1'b0, 8'(4 * i), 32'h0000_0000, d);
            check(d === w, "config readback");
        end
        // channel 0 on purpose: the late-apply checks in the design watch it
        put({6'h00, 10'h000, 11'h01A, 5'h00}, 0);
        check(chans[0] === exp_ch[0], "early apply");
        host.clocks(2);
        repeat (4) @(posedge ref_clk);
        check(chans[0] === exp_ch[0], "early apply");
        host.clocks(1);
        repeat (4) @(posedge ref_clk);
        check(chans[0] === {11'h01A, 10'h000}, "late apply");
        $display("test channels done");
        put(32'h0000_010B, 0);
        n0 = n_align;
        put({6'h00, 10'h00D, 11'h001, 5'h03}, 3);
        check(n_align === n0 + 1, "auto align");
        check(chans[3] === {11'h001, 10'h00D}, "late apply");
        put({27'h0000010, 5'h06}, 0);
        check(n_align === n0 + 1, "stray align");
        n0 = n_cal;
        put({27'h0000000, CAL_TRIG_REG}, 0);
        check(n_cal === n0 + 1, "cal start");
        put({27'h0000000, 5'h1D}, 0);
        check(n_cal === n0 + 1, "stray cal");
        $display("test events done");
        put(32'hFFFF_FFE0, 0);
        for (int i = 0; i < NUM_CH; i++) check(chans[i] === {DIV_RESET, DLY_RESET}, "soft reset");
        check(mode_state === MODE_DEC_RESET, "soft reset mode");
        av_req(1'b0, 8'h2C, 32'h0000_0000, d);
        check(d === 32'h0000_0000, "soft reset reg");
        $display("test soft reset done");
        wrap_up();
    end
endmodule // scm_serial_config_bench
`default_nettype wire
